// *** verilog/psism_top.sv ***
/*
  Interrupt summary and mask block of a four-channel power sourcing
  controller: eight-bit summary status, read/write mask, active-low
  interrupt output and clear strobes towards the event registers.
  Assumes flags and commands synchronous to clk_i, commands as one-cycle
  strobes from the host command engine, and the global enable held in
  a register outside this block.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Summary is read-only byte at command 00h; writes there do nothing.
// [RULE2] Event register clear-on-read or reset bit 7 clears matching summary bits.
// [RULE3] Interrupt asserts when an active summary bit is unmasked and enabled.
// [RULE4] Bit 7 is OR of the five supply and memory faults, one after reset.
// [RULE5] Bit 6 is OR of four start timeout faults, zero after reset.
// [RULE6] Bit 5 is OR of overload cuts, pair cuts and current-limit faults.
// [RULE7] Bit 4 is OR of four classification cycle flags.
// [RULE8] Bit 3 is OR of four detection cycle flags.
// [RULE9] Bit 2 is OR of four disconnect flags.
// [RULE10] Bit 1 is OR of four power-good change flags.
// [RULE11] Bit 0 is OR of four power-enable change flags.
// [RULE12] Mask is read/write byte at command 01h, bits aligned with summary.
// [RULE13] Mask bit zero blocks its summary bit; one lets it through.
// [RULE14] Summary follows events regardless of the mask contents.
// [RULE15] Mask resets to supply bit set, other seven bits clear.
// [RULE16] Clear-on-read returns normal data, clears event bits, releases interrupt; here clear-on-read codes read back 00h.
// [RULE17] Interrupt deasserts when nothing active is unmasked or enable drops.
module psism_top #(
  parameter int NUM_CH = 4
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  // Event and fault flags
  input  wire psism_pkg::psism_flags_t flags_i,
  input  wire logic                  global_interrupt_enable_i,
  input  wire logic                  summary_clear_all_i,
  // Host command port
  input  wire psism_pkg::psism_cmd_t cmd_i,
  output logic [7:0]                 rdata_o,
  output logic                       rvalid_o,
  // Event register clear strobes
  output logic [psism_pkg::NUM_EVT_REGS-1:0] event_clear_o,
  // Interrupt
  output logic                       int_n_o
);

  if (NUM_CH != 4) begin : g_num_ch_check
    $error("psism_top: NUM_CH must be 4");
  end

  logic [7:0] flag_or;
  logic [7:0] clr_sel;
  logic [7:0] clr_vec;
  logic [7:0] summary;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       int_n_reg;
  logic       int_n_next;
  logic [psism_pkg::NUM_EVT_REGS-1:0] evt_clr_reg;
  logic [psism_pkg::NUM_EVT_REGS-1:0] evt_clr_next;

  // Per-bit OR of the flags
  always_comb begin
    flag_or = 8'h00;
    flag_or[psism_pkg::BIT_SUPPLY] = flags_i.thermal_shutdown_flag
      | flags_i.vdd_undervoltage_flag | flags_i.vdd_warning_flag
      | flags_i.vpwr_undervoltage_flag | flags_i.sram_fault_flag; // RULE4
    flag_or[psism_pkg::BIT_START] =
      |flags_i.channel_start_timeout_flag; // RULE5
    flag_or[psism_pkg::BIT_OVCUR] = |flags_i.channel_overload_cut_flag
      | (|flags_i.pair_port_cut_flag)
      | (|flags_i.channel_current_limit_flag); // RULE6
    flag_or[psism_pkg::BIT_CLASS] =
      |flags_i.channel_classification_flag; // RULE7
    flag_or[psism_pkg::BIT_DET] =
      |flags_i.channel_detection_flag; // RULE8
    flag_or[psism_pkg::BIT_DISC] =
      |flags_i.channel_disconnect_flag; // RULE9
    flag_or[psism_pkg::BIT_PGC] =
      |flags_i.channel_power_good_change_flag; // RULE10
    flag_or[psism_pkg::BIT_PEC] =
      |flags_i.channel_power_enable_change_flag; // RULE11
  end

  // Clear-on-read decode
  always_comb begin
    clr_sel      = 8'h00;
    evt_clr_next = '0;
    if (cmd_i.rd) begin
      case (cmd_i.code)
        psism_pkg::CMD_POWER_COR: begin
          clr_sel = psism_pkg::CLR_POWER;
          evt_clr_next[psism_pkg::EVT_POWER] = 1'b1;
        end
        psism_pkg::CMD_DETECT_COR: begin
          clr_sel = psism_pkg::CLR_DETECT;
          evt_clr_next[psism_pkg::EVT_DETECT] = 1'b1;
        end
        psism_pkg::CMD_FAULT_COR: begin
          clr_sel = psism_pkg::CLR_FAULT;
          evt_clr_next[psism_pkg::EVT_FAULT] = 1'b1;
        end
        psism_pkg::CMD_START_COR: begin
          clr_sel = psism_pkg::CLR_START;
          evt_clr_next[psism_pkg::EVT_START] = 1'b1;
        end
        psism_pkg::CMD_SUPPLY_COR: begin
          clr_sel = psism_pkg::CLR_SUPPLY;
          evt_clr_next[psism_pkg::EVT_SUPPLY] = 1'b1;
        end
        default: begin
          clr_sel = 8'h00;
        end
      endcase
    end
  end

  assign clr_vec = summary_clear_all_i ? 8'hff : clr_sel; // RULE2

  // Summary bits, independent of the mask
  psism_sticky #(
    .WIDTH     (8),
    .RESET_VAL (psism_pkg::SUMMARY_RESET)
  ) u_summary (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .set_i    (flag_or), // RULE14
    .clr_i    (clr_vec), // RULE2
    .q_o      (summary)
  );

  // Mask register; summary location ignores writes
  always_comb begin
    mask_next = mask_reg;
    if (cmd_i.wr && cmd_i.code == psism_pkg::CMD_MASK) begin
      mask_next = cmd_i.wdata; // RULE12
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_reg <= psism_pkg::MASK_RESET; // RULE15
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Read data
  always_comb begin
    case (cmd_i.code)
      psism_pkg::CMD_SUMMARY: rdata_next = summary; // RULE1
      psism_pkg::CMD_MASK:    rdata_next = mask_reg; // RULE12
      default:                rdata_next = psism_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg  <= psism_pkg::READ_ZERO;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cmd_i.rd;
      if (cmd_i.rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Clear strobes to the event registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_clr_reg <= '0;
    end else begin
      evt_clr_reg <= evt_clr_next; // RULE16
    end
  end

  // Interrupt output
  assign int_n_next = ~(global_interrupt_enable_i
                        & (|(summary & mask_reg))); // RULE3 RULE13 RULE17

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_n_reg <= 1'b1;
    end else begin
      int_n_reg <= int_n_next;
    end
  end

  assign rdata_o       = rdata_reg;
  assign rvalid_o      = rvalid_reg;
  assign event_clear_o = evt_clr_reg;
  assign int_n_o       = int_n_reg;

  // Checks
  summary_ro_a: assert property ( // RULE1
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == psism_pkg::CMD_SUMMARY && clr_vec == 8'h00)
    |=> summary == ($past(summary) | $past(flag_or)))
    else $error("summary changed by a write");

  summary_clear_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (!arst_n_i)
    summary_clear_all_i |=> summary == $past(flag_or))
    else $error("clear all did not clear summary");

  cor_clear_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_POWER_COR
     && flag_or[1:0] == 2'b00) |=> summary[1:0] == 2'b00)
    else $error("power event read did not clear summary bits");

  int_assert_a: assert property ( // RULE3
    @(posedge clk_i) disable iff (!arst_n_i)
    (global_interrupt_enable_i && |(summary & mask_reg)) |=> !int_n_o)
    else $error("interrupt not asserted");

  supply_or_a: assert property ( // RULE4
    @(posedge clk_i) disable iff (!arst_n_i)
    (flags_i.thermal_shutdown_flag || flags_i.sram_fault_flag
     || flags_i.vdd_warning_flag || flags_i.vdd_undervoltage_flag
     || flags_i.vpwr_undervoltage_flag) |=> summary[psism_pkg::BIT_SUPPLY])
    else $error("supply summary bit not set");

  start_or_a: assert property ( // RULE5
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_start_timeout_flag) |=> summary[psism_pkg::BIT_START])
    else $error("start timeout summary bit not set");

  ovcur_or_a: assert property ( // RULE6
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.pair_port_cut_flag || |flags_i.channel_current_limit_flag
     || |flags_i.channel_overload_cut_flag)
    |=> summary[psism_pkg::BIT_OVCUR])
    else $error("overcurrent summary bit not set");

  class_or_a: assert property ( // RULE7
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_classification_flag) |=> summary[psism_pkg::BIT_CLASS])
    else $error("classification summary bit not set");

  detect_or_a: assert property ( // RULE8
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_detection_flag) |=> summary[psism_pkg::BIT_DET])
    else $error("detection summary bit not set");

  disc_or_a: assert property ( // RULE9
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_disconnect_flag) |=> summary[psism_pkg::BIT_DISC])
    else $error("disconnect summary bit not set");

  pgood_or_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_power_good_change_flag) |=> summary[psism_pkg::BIT_PGC])
    else $error("power good summary bit not set");

  penable_or_a: assert property ( // RULE11
    @(posedge clk_i) disable iff (!arst_n_i)
    (|flags_i.channel_power_enable_change_flag)
    |=> summary[psism_pkg::BIT_PEC])
    else $error("power enable summary bit not set");

  mask_rw_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == psism_pkg::CMD_MASK)
    ##1 (cmd_i.rd && cmd_i.code == psism_pkg::CMD_MASK && !cmd_i.wr)
    |=> rvalid_o && rdata_o == $past(cmd_i.wdata, 2))
    else $error("mask read back differs from write");

  mask_block_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (!arst_n_i)
    (mask_reg == 8'h00) |=> int_n_o)
    else $error("masked summary drove interrupt");

  mask_indep_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (!arst_n_i)
    (mask_reg == 8'h00 && flag_or != 8'h00)
    |=> (summary & $past(flag_or)) == $past(flag_or))
    else $error("summary ignored an event under full mask");

  cor_strobe_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_FAULT_COR)
    |=> event_clear_o[psism_pkg::EVT_FAULT] ##1
        !event_clear_o[psism_pkg::EVT_FAULT] || $past(cmd_i.rd))
    else $error("fault clear strobe wrong");

  int_release_a: assert property ( // RULE17
    @(posedge clk_i) disable iff (!arst_n_i)
    !global_interrupt_enable_i |=> int_n_o)
    else $error("interrupt held without enable");

  read_valid_a: assert property ( // RULE1
    @(posedge clk_i) disable iff (!arst_n_i)
    cmd_i.rd |=> rvalid_o)
    else $error("read not answered");

  read_summary_a: assert property ( // RULE1
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_SUMMARY)
    |=> rdata_o == $past(summary))
    else $error("summary read data wrong");

  read_mask_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_MASK)
    |=> rdata_o == $past(mask_reg))
    else $error("mask read data wrong");

  mask_write_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.wr && cmd_i.code == psism_pkg::CMD_MASK)
    |=> mask_reg == $past(cmd_i.wdata))
    else $error("mask write lost");

  summary_keep_a: assert property ( // RULE2
    @(posedge clk_i) disable iff (!arst_n_i)
    (clr_vec == 8'h00) |=> (summary & $past(summary)) == $past(summary))
    else $error("summary bit lost without a clear");

  power_strobe_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_POWER_COR)
    |=> event_clear_o[psism_pkg::EVT_POWER])
    else $error("power clear strobe missing");

  supply_strobe_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!arst_n_i)
    (cmd_i.rd && cmd_i.code == psism_pkg::CMD_SUPPLY_COR)
    |=> event_clear_o[psism_pkg::EVT_SUPPLY])
    else $error("supply clear strobe missing");

  strobe_idle_a: assert property ( // RULE16
    @(posedge clk_i) disable iff (!arst_n_i)
    !cmd_i.rd |=> event_clear_o == '0)
    else $error("clear strobe without a read");

  int_idle_a: assert property ( // RULE17
    @(posedge clk_i) disable iff (!arst_n_i)
    !(|(summary & mask_reg)) |=> int_n_o)
    else $error("interrupt held with nothing unmasked");

endmodule // psism_top

`default_nettype wire

// *** shared/psism_pkg.sv ***
/*
  Constants and carrier types for the interrupt summary and mask block:
  command codes, summary bit positions, reset values and the packed
  structs for per-channel flags and host commands.
  Assumes a command engine that decodes host transfers into one-cycle
  read and write strobes with an eight-bit command code.
*/
package psism_pkg;

  // Command codes
  localparam logic [7:0] CMD_SUMMARY     = 8'h00;
  localparam logic [7:0] CMD_MASK        = 8'h01;
  localparam logic [7:0] CMD_POWER_COR   = 8'h03;
  localparam logic [7:0] CMD_DETECT_COR  = 8'h05;
  localparam logic [7:0] CMD_FAULT_COR   = 8'h07;
  localparam logic [7:0] CMD_START_COR   = 8'h09;
  localparam logic [7:0] CMD_SUPPLY_COR  = 8'h0b;

  // Summary and mask bit positions
  localparam int BIT_PEC    = 0;
  localparam int BIT_PGC    = 1;
  localparam int BIT_DISC   = 2;
  localparam int BIT_DET    = 3;
  localparam int BIT_CLASS  = 4;
  localparam int BIT_OVCUR  = 5;
  localparam int BIT_START  = 6;
  localparam int BIT_SUPPLY = 7;

  // Reset values
  localparam logic [7:0] SUMMARY_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET    = 8'h80;
  localparam logic [7:0] READ_ZERO     = 8'h00;

  // Which summary bits a clear-on-read command releases
  localparam logic [7:0] CLR_POWER  = 8'h03;
  localparam logic [7:0] CLR_DETECT = 8'h18;
  localparam logic [7:0] CLR_FAULT  = 8'h24;
  localparam logic [7:0] CLR_START  = 8'h60;
  localparam logic [7:0] CLR_SUPPLY = 8'h80;

  // Number of event registers with clear-on-read strobes
  localparam int NUM_EVT_REGS = 5;
  localparam int EVT_POWER    = 0;
  localparam int EVT_DETECT   = 1;
  localparam int EVT_FAULT    = 2;
  localparam int EVT_START    = 3;
  localparam int EVT_SUPPLY   = 4;

  typedef struct packed {
    logic       thermal_shutdown_flag;
    logic       vdd_undervoltage_flag;
    logic       vdd_warning_flag;
    logic       vpwr_undervoltage_flag;
    logic       sram_fault_flag;
    logic [3:0] channel_start_timeout_flag;
    logic [3:0] channel_overload_cut_flag;
    logic [1:0] pair_port_cut_flag;
    logic [3:0] channel_current_limit_flag;
    logic [3:0] channel_classification_flag;
    logic [3:0] channel_detection_flag;
    logic [3:0] channel_disconnect_flag;
    logic [3:0] channel_power_good_change_flag;
    logic [3:0] channel_power_enable_change_flag;
  } psism_flags_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] code;
    logic [7:0] wdata;
  } psism_cmd_t;

endpackage

// *** verilog/psism_sticky.sv ***
/*
  Sticky flag register: each bit is set by its event input and cleared
  by a clear strobe; a set in the same cycle as a clear wins.
  Assumes set and clear inputs synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module psism_sticky #(
  parameter int              WIDTH     = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  // Events and clears
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // State
  output logic      [WIDTH-1:0] q_o
);

  if (WIDTH < 1) begin : g_width_check
    $error("psism_sticky: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_reg <= RESET_VAL;
    end else begin
      // Set after clear so a coinciding event is kept
      q_reg <= (q_reg & ~clr_i) | set_i;
    end
  end

  assign q_o = q_reg;

endmodule // psism_sticky

`default_nettype wire

// *** bench/psism_host.sv ***
/*
  Host model of the summary and mask block: issues one-cycle command
  strobes and collects the read answers.
  Assumes the block answers a read exactly one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none

module psism_host (
  // Clock
  input  wire logic                 clk_i,
  // Command port
  output var psism_pkg::psism_cmd_t cmd_o,
  input  wire logic [7:0]           rdata_i,
  input  wire logic                 rvalid_i
);
  initial cmd_o = '0;

  task automatic put(input logic rd, input logic [7:0] code,
                     input logic [7:0] wdata);
    @(posedge clk_i);
    cmd_o <= '{rd: rd, wr: !rd, code: code, wdata: wdata};
    @(posedge clk_i);
    cmd_o <= '0;
  endtask

  // Clear-on-read locations are read like any other
  task automatic rd(input logic [7:0] code, output logic [7:0] data,
                    output logic ok);
    put(1'b1, code, 8'h00);
    #1;
    data = rdata_i;
    ok = rvalid_i;
  endtask

  // Write followed by its read back in the very next cycle
  task automatic wr_rd(input logic [7:0] code, input logic [7:0] wdata,
                       output logic [7:0] data, output logic ok);
    @(posedge clk_i);
    cmd_o <= '{rd: 1'b0, wr: 1'b1, code: code, wdata: wdata};
    @(posedge clk_i);
    cmd_o <= '{rd: 1'b1, wr: 1'b0, code: code, wdata: 8'h00};
    @(posedge clk_i);
    cmd_o <= '0;
    #1;
    data = rdata_i;
    ok = rvalid_i;
  endtask
endmodule // psism_host

`default_nettype wire

// *** bench/tb.sv ***
/*
  Self-checking bench of the summary and mask block: reset values,
  command access, every flag source, masking, clearing and enable.
  Assumes the host model drives all commands.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(what, exp, got) begin n_compared++; \
  if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", what, exp, got); end end

module tb;
  logic                    clk_i = 1'b0;
  logic                    arst_n_i = 1'b0;
  logic                    en = 1'b1;
  logic                    clr_all = 1'b0;
  psism_pkg::psism_flags_t flags = '0;
  psism_pkg::psism_cmd_t   cmd;
  logic [7:0]              rdata;
  logic [7:0]              d;
  logic [7:0]              exp;
  logic [7:0]              code;
  logic                    rvalid;
  logic                    ok;
  logic                    int_n;
  logic [4:0]              ev;
  int                      ix;
  int                      bad_count = 0;
  int                      n_compared = 0;
  logic [$bits(psism_pkg::psism_flags_t)-1:0] fv;

  always #2.5 clk_i = ~clk_i;

  psism_top psism_top_inst (
    .clk_i                     (clk_i),
    .arst_n_i                  (arst_n_i),
    .flags_i                   (flags),
    .global_interrupt_enable_i (en),
    .summary_clear_all_i       (clr_all),
    .cmd_i                     (cmd),
    .rdata_o                   (rdata),
    .rvalid_o                  (rvalid),
    .event_clear_o             (ev),
    .int_n_o                   (int_n)
  );

  psism_host psism_host_inst (
    .clk_i    (clk_i),
    .cmd_o    (cmd),
    .rdata_i  (rdata),
    .rvalid_i (rvalid)
  );

  function automatic logic [7:0] sum_of(psism_pkg::psism_flags_t f);
    sum_of[7] = f.thermal_shutdown_flag | f.vdd_undervoltage_flag
              | f.vdd_warning_flag | f.vpwr_undervoltage_flag
              | f.sram_fault_flag;
    sum_of[6] = |f.channel_start_timeout_flag;
    sum_of[5] = |{f.channel_overload_cut_flag, f.pair_port_cut_flag,
                  f.channel_current_limit_flag};
    sum_of[4] = |f.channel_classification_flag;
    sum_of[3] = |f.channel_detection_flag;
    sum_of[2] = |f.channel_disconnect_flag;
    sum_of[1] = |f.channel_power_good_change_flag;
    sum_of[0] = |f.channel_power_enable_change_flag;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    psism_host_inst.put(1'b0, c, v);
  endtask

  task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
    psism_host_inst.rd(c, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK("rdata", e, d)
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    summarize;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(2);
    `CHK("int_n", 1'b0, int_n)
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h01, 8'h80);
    psism_host_inst.wr_rd(8'h01, 8'ha5, d, ok);
    `CHK("rvalid", 1'b1, ok)
    `CHK("mask", 8'ha5, d)
    wr(8'h00, 8'hff);
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h0b, 8'h00);
    `CHK("event_clear", 5'h10, ev)
    rd_chk(8'h00, 8'h00);
    cyc(1);
    `CHK("int_n", 1'b1, int_n)
    $display("test reset_and_access done");
    for (int k = 0; k < $bits(fv); k++) begin
      fv = '0;
      fv[k] = 1'b1;
      exp = sum_of(psism_pkg::psism_flags_t'(fv));
      wr(8'h01, exp);
      rd_chk(8'h01, exp);
      @(posedge clk_i) flags <= psism_pkg::psism_flags_t'(fv);
      @(posedge clk_i) flags <= '0;
      cyc(3);
      `CHK("int_n", 1'b0, int_n)
      rd_chk(8'h00, exp);
      wr(8'h01, 8'h00);
      cyc(2);
      `CHK("int_n", 1'b1, int_n)
      rd_chk(8'h00, exp);
      if (k % 2) begin
        @(posedge clk_i) clr_all <= 1'b1;
        @(posedge clk_i) clr_all <= 1'b0;
      end else begin
        case (exp)
          8'h01, 8'h02: begin code = 8'h03; ix = 0; end
          8'h08, 8'h10: begin code = 8'h05; ix = 1; end
          8'h04, 8'h20: begin code = 8'h07; ix = 2; end
          8'h40:        begin code = 8'h09; ix = 3; end
          default:      begin code = 8'h0b; ix = 4; end
        endcase
        rd_chk(code, 8'h00);
        `CHK("event_clear", 5'h01 << ix, ev)
      end
      rd_chk(8'h00, 8'h00);
    end
    $display("test per_flag done");
    wr(8'h01, 8'hff);
    @(posedge clk_i) flags.channel_disconnect_flag <= 4'h8;
    @(posedge clk_i) flags <= '0;
    cyc(3);
    `CHK("int_n", 1'b0, int_n)
    @(posedge clk_i) en <= 1'b0;
    cyc(2);
    `CHK("int_n", 1'b1, int_n)
    @(posedge clk_i) en <= 1'b1;
    cyc(2);
    `CHK("int_n", 1'b0, int_n)
    rd_chk(8'h07, 8'h00);
    cyc(2);
    `CHK("int_n", 1'b1, int_n)
    $display("test enable done");
    summarize;
  end
endmodule // tb

`default_nettype wire
